//--- servo_cmd_pkg.sv
/*
 * Constants of the command handler: offsets, fields, resets, codes, timing.
 * Assumes a 25 MHz clock and an AXI4-Lite bus.
 */
package servo_cmd_pkg;

    // ----------
    // Clock and timing
    // ----------
    localparam int CLK_HZ            = 25_000_000;
    localparam int BRAKE_UPDATE_US   = 2000;
    localparam int BRAKE_UPDATE_CYC  = (CLK_HZ / 1_000_000) * BRAKE_UPDATE_US;
    localparam int BRAKE_APPLY_CYC   = 2;
    localparam int TICK_MS_CYC       = CLK_HZ / 1000;

    // ----------
    // Command codes
    // ----------
    localparam logic [7:0] CMD_TORQUE  = 8'h3d;
    localparam logic [7:0] CMD_BRK_ENG = 8'h21;
    localparam logic [7:0] CMD_BRK_REL = 8'h22;

    // ----------
    // Output assignment codes
    // ----------
    localparam logic [2:0] OUT_UNUSED  = 3'h0;
    localparam logic [2:0] OUT_READY   = 3'h1;
    localparam logic [2:0] OUT_INPOS   = 3'h2;
    localparam logic [2:0] OUT_BRAKE   = 3'h3;
    localparam logic [2:0] OUT_LIMIT   = 3'h4;
    localparam logic [2:0] OUT_ZSPEED  = 3'h6;
    localparam logic [2:0] OUT_NEAR    = 3'h7;

    // ----------
    // Register byte offsets
    // ----------
    localparam logic [7:0] REG_CMD       = 8'h00;
    localparam logic [7:0] REG_TORQUE    = 8'h04;
    localparam logic [7:0] REG_SPD_LIM   = 8'h08;
    localparam logic [7:0] REG_ACC_TIME  = 8'h0c;
    localparam logic [7:0] REG_DEC_TIME  = 8'h10;
    localparam logic [7:0] REG_OUT_ASSIGN = 8'h14;
    localparam logic [7:0] REG_STATUS    = 8'h18;
    localparam logic [7:0] REG_RESP_BASE = 8'h40;
    localparam logic [7:0] REG_HOLD_MODE = 8'h1c;

    // ----------
    // Field positions and reset values
    // ----------
    localparam int CMD_CODE_LSB        = 0;
    localparam int CMD_ID_LSB          = 8;
    localparam int ASSIGN_W            = 3;
    localparam int ASSIGN_STRIDE       = 4;
    localparam logic [15:0] SPD_LIM_MAX   = 16'h2710;
    localparam logic [15:0] SPD_LIM_RST   = 16'h2710;
    localparam logic [15:0] RAMP_MAX      = 16'h2710;
    localparam logic [15:0] ACC_TIME_RST  = 16'h0000;
    localparam logic [15:0] DEC_TIME_RST  = 16'h0000;
    localparam logic [11:0] ASSIGN_RST    = 12'h513;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam int RESP_WORDS          = 8;

endpackage : servo_cmd_pkg

//--- resp_frame_mem.sv
/*
 * Word memory holding the 32-byte response frame.
 * Assumes one writer and one reader on one clock.
 */
`timescale 1ns/1ps
module resp_frame_mem #(
    parameter int WORDS = 8,
    parameter int AW    = 3
) (
    // Clock
    input  wire logic          aclk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [31:0]   wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [31:0]   rd_data
);

    logic [31:0] mem [WORDS];

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : resp_frame_mem

//--- servo_torque_brake_commands.sv
/*
 * Torque and brake command handler with ramping, speed cap and routing.
 * Assumes an AXI4-Lite master and feedback inputs on aclk.
 */
// Summary of operation
// (RQ1) Brake engage request turns the brake output off so the brake grips.
// (RQ2) Brake output follows an engage request within 2 ms.
// (RQ3) Engage request affects motion only while servo is disabled; the code never moves on engage, only a release sets a hold stop.
// (RQ4) Release request stops the axis at set position by hold stop method.
// (RQ5) Brake output activates within 2 ms after release request.
// (RQ6) Requests during servo enable leave motion alone but still drive brake.
// (RQ7) Controller should remember its last brake request before servo disable.
// (RQ8) Torque mode caps speed at 0..10000 per minute, default 10000, live.
// (RQ9) Rising torque ramps over acceleration time 0..10000 ms, default 0.
// (RQ10) Falling torque ramps over deceleration time 0..10000 ms, default 0.
// (RQ11) Three outputs routed by code; assignment latched at power-up.
// (RQ12) Each command answered with echoed code and status in a 32-byte frame.
`timescale 1ns/1ps
module servo_torque_brake_commands
    import servo_cmd_pkg::*;
#(
    parameter int BRAKE_CYC = BRAKE_UPDATE_CYC,
    parameter int MS_CYC    = TICK_MS_CYC
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Drive state and feedback
    input  wire logic        servo_enabled,
    input  wire logic        drive_ready,
    input  wire logic        in_position_or_speed_match,
    input  wire logic        near_position,
    input  wire logic        zero_speed_flag,
    input  wire logic [15:0] motor_speed,
    // Motion outputs
    output logic [15:0]      torque_reference,
    output logic [15:0]      torque_mode_speed_limit,
    output logic             hold_stop_req,
    output logic [1:0]       hold_stop_method,
    output logic             limit_active_flag,
    // General outputs
    output logic [2:0]       general_out
);

    // ----------
    // State
    // ----------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic        arready;
        logic        rvalid;
        logic        rpend;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        rmem;
        logic [15:0] torque_target;
        logic [15:0] torque_now;
        logic [15:0] spd_lim;
        logic [15:0] acc_time;
        logic [15:0] dec_time;
        logic [11:0] assign_cfg;
        logic [11:0] assign_live;
        logic        assign_done;
        logic [1:0]  hold_mode;
        logic        brake_on;
        logic        brake_pend;
        logic        brake_pend_val;
        logic [31:0] brake_cnt;
        logic        hold_req;
        logic [31:0] ms_cnt;
        logic [15:0] ramp_cnt;
        logic [7:0]  last_code;
        logic [7:0]  last_id;
        logic [3:0]  resp_idx;
        logic        resp_busy;
        logic [2:0]  gen_out;
        logic        limit;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [31:0] mem_rdata;
    logic        mem_wr;
    logic [2:0]  mem_waddr;
    logic [31:0] mem_wdata;
    logic [2:0]  mem_raddr;

    resp_frame_mem #(
        .WORDS (RESP_WORDS),
        .AW    (3)
    ) u_resp (
        .aclk    (aclk),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // ----------
    // Response frame writer
    // ----------
    always_comb begin
        mem_wr    = st_r.resp_busy;
        mem_waddr = st_r.resp_idx[2:0];
        mem_raddr = (s_axi_arvalid && st_r.arready) ? s_axi_araddr[4:2] : st_r.aw_addr[4:2];
        case (st_r.resp_idx[2:0])
            3'h0:    mem_wdata = {8'h00, st_r.last_id, 7'h00, servo_enabled, st_r.last_code}; // see (RQ12)
            3'h1:    mem_wdata = {15'h0000, st_r.brake_on, st_r.torque_now};
            3'h2:    mem_wdata = {16'h0000, motor_speed};
            3'h3:    mem_wdata = {16'h0000, st_r.torque_target};
            3'h4:    mem_wdata = {16'h0000, st_r.spd_lim};
            default: mem_wdata = 32'h0000_0000;
        endcase
    end

    // ----------
    // Next-state logic
    // ----------
    logic        wr_fire;
    logic [15:0] wval;
    logic [15:0] ramp_time;
    logic [15:0] step;
    logic [2:0]  code;
    logic        sel;

    always_comb begin
        st_nxt  = st_r;
        wr_fire = 1'b0;
        wval    = 16'h0000;
        ramp_time = 16'h0000;
        step    = 16'h0000;
        code    = 3'h0;
        sel     = 1'b0;

        // Write channel: address and data taken in either order.
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.awready = 1'b0;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wready = 1'b0;
            st_nxt.w_data = s_axi_wdata;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_fire       = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end

        wval = st_r.w_data[15:0];
        if (wr_fire) begin
            if (st_r.aw_addr == REG_CMD) begin
                st_nxt.last_code = st_r.w_data[CMD_CODE_LSB +: 8];
                st_nxt.last_id   = st_r.w_data[CMD_ID_LSB +: 8];
                st_nxt.resp_busy = 1'b1;
                st_nxt.resp_idx  = 4'h0;
                if (st_r.w_data[CMD_CODE_LSB +: 8] == CMD_BRK_ENG) begin
                    st_nxt.brake_pend     = 1'b1; // see (RQ1) (RQ6)
                    st_nxt.brake_pend_val = 1'b0;
                    st_nxt.brake_cnt      = 32'h0000_0000;
                end else if (st_r.w_data[CMD_CODE_LSB +: 8] == CMD_BRK_REL) begin
                    st_nxt.brake_pend     = 1'b1; // see (RQ5) (RQ6)
                    st_nxt.brake_pend_val = 1'b1;
                    st_nxt.brake_cnt      = 32'h0000_0000;
                    st_nxt.hold_req       = !servo_enabled; // see (RQ4) (RQ6)
                end else if (st_r.w_data[CMD_CODE_LSB +: 8] != CMD_TORQUE) begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            end else if (st_r.aw_addr == REG_TORQUE) begin
                st_nxt.torque_target = wval;
            end else if (st_r.aw_addr == REG_SPD_LIM) begin
                st_nxt.spd_lim = (wval > SPD_LIM_MAX) ? SPD_LIM_MAX : wval; // see (RQ8)
            end else if (st_r.aw_addr == REG_ACC_TIME) begin
                st_nxt.acc_time = (wval > RAMP_MAX) ? RAMP_MAX : wval; // see (RQ9)
            end else if (st_r.aw_addr == REG_DEC_TIME) begin
                st_nxt.dec_time = (wval > RAMP_MAX) ? RAMP_MAX : wval; // see (RQ10)
            end else if (st_r.aw_addr == REG_OUT_ASSIGN) begin
                st_nxt.assign_cfg = st_r.w_data[11:0];
            end else if (st_r.aw_addr == REG_HOLD_MODE) begin
                st_nxt.hold_mode = st_r.w_data[1:0];
            end else begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end

        // Read channel; response words come from memory one cycle later.
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rpend   = 1'b1;
            st_nxt.rmem    = (s_axi_araddr >= REG_RESP_BASE) && (s_axi_araddr < REG_RESP_BASE + 8'h20);
            st_nxt.aw_addr = st_r.aw_got ? st_r.aw_addr : s_axi_araddr;
            st_nxt.rresp   = RESP_OKAY;
            if (s_axi_araddr == REG_TORQUE) begin
                st_nxt.rdata = {16'h0000, st_r.torque_target};
            end else if (s_axi_araddr == REG_CMD) begin
                st_nxt.rdata = {16'h0000, st_r.last_id, st_r.last_code};
            end else if (s_axi_araddr == REG_SPD_LIM) begin
                st_nxt.rdata = {16'h0000, st_r.spd_lim};
            end else if (s_axi_araddr == REG_ACC_TIME) begin
                st_nxt.rdata = {16'h0000, st_r.acc_time};
            end else if (s_axi_araddr == REG_DEC_TIME) begin
                st_nxt.rdata = {16'h0000, st_r.dec_time};
            end else if (s_axi_araddr == REG_OUT_ASSIGN) begin
                st_nxt.rdata = {4'h0, st_r.assign_live, 4'h0, st_r.assign_cfg};
            end else if (s_axi_araddr == REG_HOLD_MODE) begin
                st_nxt.rdata = {30'h0, st_r.hold_mode};
            end else if (s_axi_araddr == REG_STATUS) begin
                st_nxt.rdata = {11'h0, st_r.limit, st_r.hold_req, st_r.brake_pend,
                                servo_enabled, st_r.brake_on, st_r.torque_now};
            end else if (st_nxt.rmem) begin
                st_nxt.rdata = 32'h0;
            end else begin
                st_nxt.rdata = 32'h0;
                st_nxt.rresp = RESP_SLVERR;
            end
        end
        if (st_r.rpend && !st_r.aw_got) begin
            st_nxt.rpend  = 1'b0;
            st_nxt.rvalid = 1'b1;
            if (st_r.rmem) begin
                st_nxt.rdata = mem_rdata;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // Response frame fill.
        if (st_r.resp_busy) begin
            st_nxt.resp_idx = st_r.resp_idx + 4'h1;
            if (st_r.resp_idx == 4'h7) begin
                st_nxt.resp_busy = 1'b0;
            end
        end

        // Brake output applied after a short fixed delay, well within the limit.
        if (st_r.brake_pend) begin
            st_nxt.brake_cnt = st_r.brake_cnt + 32'h1;
            if (st_r.brake_cnt >= 32'(BRAKE_APPLY_CYC) || st_r.brake_cnt >= 32'(BRAKE_CYC - 1)) begin
                st_nxt.brake_on   = st_r.brake_pend_val; // see (RQ2) (RQ5)
                st_nxt.brake_pend = 1'b0;
            end
        end
        if (servo_enabled) begin
            st_nxt.hold_req = 1'b0; // see (RQ3)
        end

        // Millisecond tick and torque ramp.
        st_nxt.ms_cnt = (st_r.ms_cnt >= 32'(MS_CYC - 1)) ? 32'h0 : st_r.ms_cnt + 32'h1;
        ramp_time = (st_r.torque_target > st_r.torque_now) ? st_r.acc_time : st_r.dec_time;
        step = (ramp_time == 16'h0000) ? 16'hffff : (RAMP_MAX / ramp_time);
        if (step == 16'h0000) begin
            step = 16'h0001;
        end
        if (ramp_time == 16'h0000 || st_r.ms_cnt == 32'h0) begin
            if (st_r.torque_target > st_r.torque_now) begin
                st_nxt.torque_now = (st_r.torque_target - st_r.torque_now > step) ?
                                    st_r.torque_now + step : st_r.torque_target; // see (RQ9)
            end else if (st_r.torque_target < st_r.torque_now) begin
                st_nxt.torque_now = (st_r.torque_now - st_r.torque_target > step) ?
                                    st_r.torque_now - step : st_r.torque_target; // see (RQ10)
            end
        end

        st_nxt.limit = (st_r.last_code == CMD_TORQUE) && (motor_speed >= st_r.spd_lim); // see (RQ8)

        // Output assignment taken once after reset.
        if (!st_r.assign_done) begin
            st_nxt.assign_live = st_r.assign_cfg; // see (RQ11)
            st_nxt.assign_done = 1'b1;
        end
        for (int i = 0; i < 3; i++) begin
            code = st_r.assign_live[i*ASSIGN_STRIDE +: ASSIGN_W];
            case (code)
                OUT_READY:  sel = drive_ready;
                OUT_INPOS:  sel = in_position_or_speed_match;
                OUT_BRAKE:  sel = st_r.brake_on;
                OUT_LIMIT:  sel = st_r.limit;
                OUT_ZSPEED: sel = zero_speed_flag;
                OUT_NEAR:   sel = near_position;
                default:    sel = 1'b0;
            endcase
            st_nxt.gen_out[i] = sel; // see (RQ11)
        end
    end

    // ----------
    // Registers
    // ----------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r            <= '0;
            st_r.awready    <= 1'b1;
            st_r.wready     <= 1'b1;
            st_r.arready    <= 1'b1;
            st_r.spd_lim    <= SPD_LIM_RST;
            st_r.acc_time   <= ACC_TIME_RST;
            st_r.dec_time   <= DEC_TIME_RST;
            st_r.assign_cfg <= ASSIGN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rdata   = st_r.rdata;
    assign torque_reference        = st_r.torque_now;
    assign torque_mode_speed_limit = st_r.spd_lim;
    assign hold_stop_req           = st_r.hold_req;
    assign hold_stop_method        = st_r.hold_mode;
    assign limit_active_flag       = st_r.limit;
    assign general_out             = st_r.gen_out;

endmodule : servo_torque_brake_commands

//--- servo_torque_brake_commands_assertions.sv
/*
 * Port-level checks of the command handler.
 * Assumes binding into the top module; sees only its ports.
 */
`timescale 1ns/1ps
module servo_cmd_checker
    import servo_cmd_pkg::*;
#(
    parameter int BRAKE_CYC = 8,
    parameter int MS_CYC    = 10
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Drive side
    input wire logic        servo_enabled,
    input wire logic        hold_stop_req,
    input wire logic [15:0] torque_mode_speed_limit,
    input wire logic [2:0]  general_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A command word taken in one edge with its address.
    wire cmd_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & (s_axi_awaddr == REG_CMD);
    wire [7:0] code = s_axi_wdata[7:0];

    property p_engage; cmd_go && code == CMD_BRK_ENG |-> ##[1:12] !general_out[0]; endproperty
    a_engage: assert property (p_engage) else $error("brake output not engaged in time");
    property p_release; cmd_go && code == CMD_BRK_REL |-> ##[1:12] general_out[0]; endproperty
    a_release: assert property (p_release) else $error("brake output not released in time");
    property p_hold;
        (cmd_go && code == CMD_BRK_REL && !servo_enabled) ##1 (!servo_enabled)[*8] |-> hold_stop_req;
    endproperty
    a_hold: assert property (p_hold) else $error("release did not request a hold stop");
    property p_no_hold; servo_enabled[*3] |-> !hold_stop_req; endproperty
    a_no_hold: assert property (p_no_hold) else $error("hold stop while servo on");
    property p_lim_max; torque_mode_speed_limit <= SPD_LIM_MAX; endproperty
    a_lim_max: assert property (p_lim_max) else $error("speed limit above maximum");
    property p_lim_rst; $rose(aresetn) |-> ##2 torque_mode_speed_limit == SPD_LIM_RST; endproperty
    a_lim_rst: assert property (p_lim_rst) else $error("speed limit default wrong");
    property p_answer; cmd_go |-> ##[1:4] s_axi_bvalid; endproperty
    a_answer: assert property (p_answer) else $error("command not answered");
    property p_bstand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bstand: assert property (p_bstand) else $error("write response dropped");
    property p_one_wr; s_axi_awvalid && s_axi_awready |=> !s_axi_awready until s_axi_bvalid; endproperty
    a_one_wr: assert property (p_one_wr) else $error("second write accepted early");
    property p_rd; s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");

    c_engage: cover property (cmd_go && code == CMD_BRK_ENG && servo_enabled);
    c_release: cover property (cmd_go && code == CMD_BRK_REL && !servo_enabled);
    c_hold: cover property ($rose(hold_stop_req));
endmodule : servo_cmd_checker

bind servo_torque_brake_commands servo_cmd_checker #(.BRAKE_CYC(BRAKE_CYC), .MS_CYC(MS_CYC)) u_servo_cmd_checker (.*);

//--- drive_model.sv
/*
 * Drive feedback model: speed follows torque.
 * Assumes the handler's clock; ready comes from the bench.
 */
`timescale 1ns/1ps
module drive_model (
    // Clock and control
    input  wire logic        aclk,
    input  wire logic        ready_in,
    input  wire logic [15:0] torque_reference,
    // Feedback
    output logic             drive_ready,
    output logic [15:0]      motor_speed,
    output logic             zero_speed_flag,
    output logic             near_position,
    output logic             in_position_or_speed_match
);
    always @(posedge aclk) begin
        drive_ready <= ready_in;
        motor_speed <= torque_reference;
    end
    assign zero_speed_flag            = (motor_speed == 16'h0000);
    assign near_position              = (motor_speed < 16'h0064);
    assign in_position_or_speed_match = near_position;
endmodule : drive_model

//--- servo_torque_brake_commands_tb.sv
/*
 * Self-checking bench of the command handler.
 * Assumes the drive model on the feedback side.
 */
`timescale 1ns/1ps
module servo_torque_brake_commands_tb;
    import servo_cmd_pkg::*;
    localparam int BRK = 8;
    logic        aclk = 1'b0, aresetn = 1'b0, servo_enabled = 1'b0, ready_in = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, hold_stop_method, r;
    logic        drive_ready, in_position_or_speed_match, near_position, zero_speed_flag;
    logic [15:0] motor_speed, torque_reference, torque_mode_speed_limit;
    logic        hold_stop_req, limit_active_flag;
    logic [2:0]  general_out;
    logic        brk_hist[$];
    int          err_count = 0, n_compared = 0;
    logic [7:0]  ra[4] = '{REG_SPD_LIM, REG_ACC_TIME, REG_DEC_TIME, REG_OUT_ASSIGN};
    logic [31:0] rv[4] = '{32'(SPD_LIM_RST), 32'(ACC_TIME_RST), 32'(DEC_TIME_RST), 32'(ASSIGN_RST)};

    always #20 aclk = ~aclk;
    servo_torque_brake_commands #(.BRAKE_CYC(BRK), .MS_CYC(10)) u_servo_torque_brake_commands (.*);
    drive_model u_drive_model (.*);

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tmo;
        err_count++;
        $display("wrong value at %0t ns: no bus answer", $time);
        results();
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) tmo();
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) tmo();
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // Sends a command, waits the brake delay, checks the echo.
    task automatic cmd(input logic [7:0] c, input logic [1:0] er);
        logic [7:0] id;
        id = 8'($urandom);
        wr(REG_CMD, {16'h0000, id, c}, r);
        chk(r, er, "command response");
        repeat (BRK) @(posedge aclk);
        rd(REG_RESP_BASE, d, r);
        if (er === RESP_OKAY) chk(d[7:0], c, "echoed code");
    endtask : cmd

    initial begin
        int i;
        logic [15:0] v;
        void'($urandom(69));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(ra[i], d, r);
            chk(d & 32'h0000_ffff, rv[i], "reset value");
        end
        rd(8'hfc, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        wr(8'hf8, 32'h0, r);
        chk(r, RESP_SLVERR, "unmapped write");
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            wr(REG_HOLD_MODE, 32'(i), r);
            cmd(CMD_BRK_ENG, RESP_OKAY);
            brk_hist.push_back(1'b0);
            chk(general_out[0], 1'b0, "engage");
            cmd(CMD_BRK_REL, RESP_OKAY);
            brk_hist.push_back(1'b1);
            chk(general_out[0], 1'b1, "release");
            chk(hold_stop_req, 1'b1, "hold stop");
            chk(hold_stop_method, i[1:0], "hold method");
        end
        servo_enabled <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(hold_stop_req, 1'b0, "hold cleared");
        cmd(CMD_BRK_ENG, RESP_OKAY);
        chk({hold_stop_req, general_out[0]}, 2'b00, "engage servo on");
        cmd(CMD_BRK_REL, RESP_OKAY);
        brk_hist.push_back(1'b1);
        chk({hold_stop_req, general_out[0]}, 2'b01, "release servo on");
        cmd(8'h55, RESP_SLVERR);
        chk(general_out[0], brk_hist[$], "bad code");
        $display("test brake done");
        wr(REG_SPD_LIM, 32'd20000, r);
        rd(REG_SPD_LIM, d, r);
        chk({d[15:0], torque_mode_speed_limit}, {SPD_LIM_MAX, SPD_LIM_MAX}, "limit clamp");
        v = 16'($urandom_range(9999, 1));
        wr(REG_SPD_LIM, 32'(v), r);
        repeat (2) @(posedge aclk);
        chk(torque_mode_speed_limit, v, "limit live");
        wr(REG_ACC_TIME, 32'd5, r);
        wr(REG_TORQUE, 32'd10000, r);
        cmd(CMD_TORQUE, RESP_OKAY);
        chk(torque_reference < 16'd10000, 1'b1, "ramping up");
        repeat (60) @(posedge aclk);
        chk(torque_reference, 16'd10000, "ramp top");
        chk(limit_active_flag, 1'b1, "limit active");
        wr(REG_DEC_TIME, 32'd4, r);
        wr(REG_TORQUE, 32'd0, r);
        cmd(CMD_TORQUE, RESP_OKAY);
        chk(torque_reference > 16'd0, 1'b1, "ramping down");
        repeat (50) @(posedge aclk);
        chk(torque_reference, 16'd0, "ramp bottom");
        wr(REG_ACC_TIME, 32'd0, r);
        v = 16'($urandom_range(9999, 1));
        wr(REG_TORQUE, 32'(v), r);
        cmd(CMD_TORQUE, RESP_OKAY);
        chk(torque_reference, v, "no ramp");
        $display("test torque done");
        ready_in <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(general_out[1], 1'b1, "ready routed");
        wr(REG_OUT_ASSIGN, 32'h0, r);
        ready_in <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(general_out[1:0], {1'b0, brk_hist[$]}, "routing kept");
        $display("test outputs done");
        results();
    end
endmodule : servo_torque_brake_commands_tb
